// ### hw/ocsbl_top.sv
// Four overcurrent stages with angle measurement: blocking, start and trip, events, counters and fault records.
// Assumes register access over a plain strobe port and measurements from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module ocsbl_top #(
  parameter int CLKS_PER_MS = ocsbl_pkg::MS_NS / ocsbl_pkg::CLK_NS
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [ocsbl_pkg::AW-1:0] i_addr,
  input wire logic [ocsbl_pkg::DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [ocsbl_pkg::DW-1:0] o_rdata,
  input wire logic [ocsbl_pkg::NSTG-1:0] i_block,
  input wire ocsbl_pkg::ocsbl_meas_t i_meas,
  output logic [ocsbl_pkg::NSTG-1:0] o_start,
  output logic [ocsbl_pkg::NSTG-1:0] o_trip,
  output logic [ocsbl_pkg::NSTG-1:0] o_blocked,
  output ocsbl_pkg::ocsbl_evt_t o_evt [ocsbl_pkg::NSTG]
);
  import ocsbl_pkg::*;
  localparam int DIVW = $clog2(CLKS_PER_MS + 1);
  localparam int RIW = $clog2(NREC);

  function automatic ocsbl_time_t remain(input ocsbl_stg_t s);
    return (s.state == ST_START) ? s.expt - s.elap : '0;
  endfunction

  function automatic logic [DW-1:0] stage_word(input ocsbl_stg_t s, input logic [3:0] idx,
                                               input logic [RIW-1:0] rcnt);
    logic [DW-1:0] w;
    w = '0;
    unique case (idx)
      R_CTRL: w = DW'({s.inverse, s.inr_en});
      R_ISET: w = DW'(s.iset);
      R_TDLY: w = DW'(s.tdly);
      R_HLIM: w = DW'(s.hlim);
      R_EVSEL: w = DW'(s.evsel);
      R_STAT: w = DW'({s.pu, s.blk, s.lev});
      R_EXPT: w = DW'(s.expt);
      R_REMT: w = DW'(remain(s));
      R_RATIO: w = s.ratio;
      R_ANGLE: w = DW'(s.angle);
      R_CSTART: w = DW'(s.cnt_s);
      R_CTRIP: w = DW'(s.cnt_t);
      R_CBLK: w = DW'(s.cnt_b);
      R_RCNT: w = DW'(rcnt);
      default: w = '0;
    endcase
    return w;
  endfunction

  function automatic logic [DW-1:0] rec_word(input ocsbl_rec_t r, input logic [2:0] word);
    logic [DW-1:0] w;
    w = '0;
    unique case (word)
      W_STAMP: w = r.stamp;
      W_INFO: w = DW'({r.code, r.phases, r.sgrp});
      W_IPRE: w = DW'(r.ipre);
      W_IFLT: w = DW'(r.ifault);
      W_IAVG: w = DW'(r.iavg);
      W_TREM: w = DW'(r.tremain);
      W_ANGLE: w = DW'(r.angle);
      default: w = '0;
    endcase
    return w;
  endfunction

  logic [DIVW-1:0] ms_div, next_ms_div;
  logic [2:0] tick_ms, next_tick_ms;
  logic [DW-1:0] stamp, next_stamp;
  logic ms_wrap;
  logic tick;
  logic [NSTG-1:0] blk_s1, blk_s2, blk_s3, blk_f, next_blk_f;
  logic [DW-1:0] next_rdata;
  ocsbl_raddr_t sa;
  ocsbl_faddr_t fa;
  ocsbl_stg_t stg [NSTG];
  ocsbl_stg_t next_stg [NSTG];
  ocsbl_rec_t rec_rd [NSTG];
  logic [RIW-1:0] rec_cnt [NSTG];

  assign sa = i_addr;
  assign fa = i_addr;
  assign ms_wrap = (ms_div == DIVW'(CLKS_PER_MS - 1));
  assign tick = ms_wrap && (tick_ms == 3'(TICK_MS - 1));

  // The program cycle tick and the millisecond stamp share one divider so stamps never drift from cycles.
  always_comb
  begin
    next_ms_div = ms_wrap ? '0 : ms_div + DIVW'(1);
    next_stamp = ms_wrap ? stamp + DW'(1) : stamp;
    next_tick_ms = tick_ms;
    if (ms_wrap)
      next_tick_ms = tick ? '0 : tick_ms + 3'(1);
    // A block change counts only once the two later synchroniser stages agree.
    next_blk_f = (blk_s2 & blk_s3) | (blk_f & (blk_s2 ^ blk_s3));
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ms_div <= '0;
      tick_ms <= '0;
      stamp <= '0;
      blk_s1 <= '0;
      blk_s2 <= '0;
      blk_s3 <= '0;
      blk_f <= '0;
    end
    else
    begin
      ms_div <= next_ms_div;
      tick_ms <= next_tick_ms;
      stamp <= next_stamp;
      blk_s1 <= i_block;
      blk_s2 <= blk_s1;
      blk_s3 <= blk_s2;
      blk_f <= next_blk_f;
    end
  end

  for (genvar g = 0; g < NSTG; g++)
  begin : g_stage
    logic pu_set;
    logic pu_clr;
    logic inr;
    ocsbl_val_t den;
    ocsbl_val_t rden;
    logic [DW-1:0] quot;
    ocsbl_time_t expt_calc;
    logic [DW-1:0] ratio_calc;

    assign pu_set = i_meas.imax > stg[g].iset;
    assign pu_clr = DW'(i_meas.imax) * DW'(FULL_PCT) < DW'(stg[g].iset) * DW'(RESET_PCT);
    assign inr = stg[g].inr_en && (i_meas.i2h > stg[g].hlim);
    assign den = pu_set ? i_meas.imax - stg[g].iset : ocsbl_val_t'(1);
    assign quot = (DW'(stg[g].tdly) * DW'(stg[g].iset)) / DW'(den);
    // Below pick-up the inverse curve has no finite time, so the longest time is shown.
    assign expt_calc = !stg[g].inverse ? ocsbl_time_t'(stg[g].tdly) :
                       (!pu_set || quot > DW'(MAX_TICKS)) ? MAX_TICKS : ocsbl_time_t'(quot);
    assign rden = (stg[g].iset == '0) ? ocsbl_val_t'(1) : stg[g].iset;
    assign ratio_calc = (DW'(i_meas.imax) * DW'(FULL_PCT)) / DW'(rden);

    always_comb
    begin
      logic pu_n;
      logic blk_now;
      logic clr;
      logic [NEV-1:0] nl;
      logic [NEV-1:0] rise;
      logic [NEV-1:0] fall;
      pu_n = stg[g].pu;
      blk_now = stg[g].blk | inr;
      clr = 1'b0;
      nl = stg[g].lev;
      rise = '0;
      fall = '0;
      next_stg[g] = stg[g];
      next_stg[g].evt.valid = 1'b0;
      next_stg[g].rec_wr = 1'b0;
      if (i_wr && !sa.rec && sa.pad == '0 && sa.stage == ocsbl_sid_t'(g))
      begin
        unique case (sa.idx)
          R_CTRL:
          begin
            next_stg[g].inr_en = i_wdata[CTRL_INRUSH];
            next_stg[g].inverse = i_wdata[CTRL_INVERSE];
            clr = i_wdata[CTRL_CLEAR];
          end
          R_ISET: next_stg[g].iset = ocsbl_val_t'(i_wdata);
          R_TDLY: next_stg[g].tdly = ocsbl_val_t'(i_wdata);
          R_HLIM: next_stg[g].hlim = ocsbl_val_t'(i_wdata);
          R_EVSEL: next_stg[g].evsel = ocsbl_evsel_t'(i_wdata);
          default: next_stg[g].evsel = stg[g].evsel;
        endcase
      end
      if (tick)
      begin
        blk_now = blk_f[g] | inr;
        next_stg[g].blk = blk_f[g];
        pu_n = stg[g].pu ? !pu_clr : pu_set;
        next_stg[g].pu = pu_n;
        next_stg[g].expt = expt_calc;
        next_stg[g].ratio = ratio_calc;
        if (!i_meas.vlow)
        begin
          next_stg[g].vref = i_meas.uang;
          next_stg[g].vcnt = '0;
        end
        else if (stg[g].vcnt < VMEM_TICKS)
          next_stg[g].vcnt = stg[g].vcnt + VCW'(1);
        else
          next_stg[g].vref = '0;
        next_stg[g].angle = ocsbl_ang_t'(i_meas.iang - next_stg[g].vref);
        unique case (stg[g].state)
          ST_IDLE:
          begin
            next_stg[g].elap = '0;
            if (pu_n)
              next_stg[g].state = blk_now ? ST_BLKD : ST_START;
          end
          ST_START, ST_TRIP:
          begin
            if (!pu_n || blk_now)
            begin
              next_stg[g].state = pu_n ? ST_BLKD : ST_IDLE;
              next_stg[g].elap = '0;
            end
            else if (stg[g].state == ST_START)
            begin
              next_stg[g].elap = stg[g].elap + ocsbl_time_t'(1);
              if (stg[g].elap + ocsbl_time_t'(1) >= expt_calc)
                next_stg[g].state = ST_TRIP;
            end
          end
          ST_BLKD:
            if (!pu_n || !blk_now)
              next_stg[g].state = ST_IDLE;
        endcase
        nl[EV_START] = (next_stg[g].state == ST_START) || (next_stg[g].state == ST_TRIP);
        nl[EV_TRIP] = next_stg[g].state == ST_TRIP;
        nl[EV_BLOCK] = next_stg[g].state == ST_BLKD;
        nl[EV_NOVOLT] = i_meas.vlow && next_stg[g].vcnt >= VMEM_TICKS;
        nl[EV_LIVE] = !i_meas.vlow;
        nl[EV_VMEM] = i_meas.vlow && next_stg[g].vcnt < VMEM_TICKS;
        rise = nl & ~stg[g].lev;
        fall = ~nl & stg[g].lev;
        next_stg[g].lev = nl;
        next_stg[g].evt.on = rise & stg[g].evsel.on;
        next_stg[g].evt.off = fall & stg[g].evsel.off;
        next_stg[g].evt.valid = |{next_stg[g].evt.on, next_stg[g].evt.off};
        next_stg[g].evt.stage = ocsbl_sid_t'(g);
        next_stg[g].evt.stamp = stamp;
        if (rise[EV_START] || rise[EV_TRIP] || rise[EV_BLOCK])
        begin
          next_stg[g].rec_wr = 1'b1;
          next_stg[g].rec.code = rise[EV_TRIP] ? RC_TRIP : rise[EV_BLOCK] ? RC_BLOCKED : RC_START;
          next_stg[g].rec.stamp = stamp;
          next_stg[g].rec.phases = i_meas.phases;
          next_stg[g].rec.ipre = i_meas.ipre;
          next_stg[g].rec.ifault = i_meas.imax;
          next_stg[g].rec.iavg = i_meas.iavg;
          next_stg[g].rec.tremain = remain(next_stg[g]);
          next_stg[g].rec.sgrp = i_meas.sgrp;
          next_stg[g].rec.angle = next_stg[g].angle;
        end
      end
      // A count that lands with a clear survives it.
      next_stg[g].cnt_s = (clr ? '0 : stg[g].cnt_s) + CW'(rise[EV_START]);
      next_stg[g].cnt_t = (clr ? '0 : stg[g].cnt_t) + CW'(rise[EV_TRIP]);
      next_stg[g].cnt_b = (clr ? '0 : stg[g].cnt_b) + CW'(rise[EV_BLOCK]);
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
      if (!i_nrst)
        stg[g] <= STG_RST;
      else
        stg[g] <= next_stg[g];
    end

    ocsbl_flog u_flog (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_wr(stg[g].rec_wr),
      .i_rec(stg[g].rec),
      .i_idx(fa.entry),
      .o_rec(rec_rd[g]),
      .o_count(rec_cnt[g])
    );

    assign o_start[g] = stg[g].lev[EV_START];
    assign o_trip[g] = stg[g].lev[EV_TRIP];
    assign o_blocked[g] = stg[g].lev[EV_BLOCK];
    assign o_evt[g] = stg[g].evt;
  end

  // Read data is zero outside the cycle after a read strobe and for unmapped addresses.
  always_comb
  begin
    next_rdata = '0;
    if (i_rd && fa.rec)
      next_rdata = rec_word(rec_rd[fa.stage], fa.word);
    else if (i_rd && sa.pad == '0)
      next_rdata = stage_word(stg[sa.stage], sa.idx, rec_cnt[sa.stage]);
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_rdata <= '0;
    else
      o_rdata <= next_rdata;
  end
endmodule
`default_nettype wire

// ### hw/ocsbl_pkg.sv
// Shared constants, register map and carrier types of the overcurrent stage event block.
// Assumes a 40 MHz clock and a measurement front end that delivers values once per program cycle.
package ocsbl_pkg;
  localparam int NSTG = 4;
  localparam int NREC = 12;
  localparam int NEV = 6;
  localparam int AW = 10;
  localparam int DW = 32;
  localparam int TW = 20;
  localparam int CW = 16;
  localparam int VCW = 8;
  localparam int NPH = 4;
  localparam int SGW = 3;
  localparam int CLK_NS = 25;
  localparam int MS_NS = 1000000;
  localparam int TICK_MS = 5;
  localparam int VMEM_MS = 500;
  localparam int MAX_MS = 1800000;
  localparam int RESET_PCT = 97;
  localparam int FULL_PCT = 100;
  localparam logic [VCW-1:0] VMEM_TICKS = VCW'(VMEM_MS / TICK_MS);
  localparam logic [TW-1:0] MAX_TICKS = TW'(MAX_MS / TICK_MS);
  // Event indices into level, on and off vectors.
  localparam int EV_START = 0;
  localparam int EV_TRIP = 1;
  localparam int EV_BLOCK = 2;
  localparam int EV_NOVOLT = 3;
  localparam int EV_LIVE = 4;
  localparam int EV_VMEM = 5;
  // Stage register word indices.
  localparam logic [3:0] R_CTRL = 4'h0;
  localparam logic [3:0] R_ISET = 4'h1;
  localparam logic [3:0] R_TDLY = 4'h2;
  localparam logic [3:0] R_HLIM = 4'h3;
  localparam logic [3:0] R_EVSEL = 4'h4;
  localparam logic [3:0] R_STAT = 4'h5;
  localparam logic [3:0] R_EXPT = 4'h6;
  localparam logic [3:0] R_REMT = 4'h7;
  localparam logic [3:0] R_RATIO = 4'h8;
  localparam logic [3:0] R_ANGLE = 4'h9;
  localparam logic [3:0] R_CSTART = 4'ha;
  localparam logic [3:0] R_CTRIP = 4'hb;
  localparam logic [3:0] R_CBLK = 4'hc;
  localparam logic [3:0] R_RCNT = 4'hd;
  localparam int CTRL_INRUSH = 0;
  localparam int CTRL_INVERSE = 1;
  localparam int CTRL_CLEAR = 2;
  // Fault record word indices.
  localparam logic [2:0] W_STAMP = 3'h0;
  localparam logic [2:0] W_INFO = 3'h1;
  localparam logic [2:0] W_IPRE = 3'h2;
  localparam logic [2:0] W_IFLT = 3'h3;
  localparam logic [2:0] W_IAVG = 3'h4;
  localparam logic [2:0] W_TREM = 3'h5;
  localparam logic [2:0] W_ANGLE = 3'h6;
  localparam logic [1:0] RC_START = 2'h1;
  localparam logic [1:0] RC_TRIP = 2'h2;
  localparam logic [1:0] RC_BLOCKED = 2'h3;
  localparam logic [15:0] ISET_RST = 16'h0078;
  localparam logic [15:0] TDLY_RST = 16'h0014;
  localparam logic [15:0] HLIM_RST = 16'h0001;
  typedef logic [15:0] ocsbl_val_t;
  typedef logic [TW-1:0] ocsbl_time_t;
  typedef logic signed [16:0] ocsbl_ang_t;
  typedef logic [1:0] ocsbl_sid_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_START = 2'b01, ST_TRIP = 2'b10, ST_BLKD = 2'b11} ocsbl_state_t;
  typedef struct packed {logic rec; logic [2:0] pad; ocsbl_sid_t stage; logic [3:0] idx;} ocsbl_raddr_t;
  typedef struct packed {logic rec; ocsbl_sid_t stage; logic [3:0] entry; logic [2:0] word;} ocsbl_faddr_t;
  typedef struct packed {logic [NEV-1:0] off; logic [NEV-1:0] on;} ocsbl_evsel_t;
  typedef struct packed {
    ocsbl_val_t imax; ocsbl_val_t i2h; ocsbl_val_t ipre; ocsbl_val_t iavg;
    ocsbl_ang_t iang; ocsbl_ang_t uang; logic vlow; logic [NPH-1:0] phases; logic [SGW-1:0] sgrp;
  } ocsbl_meas_t;
  typedef struct packed {
    logic valid; ocsbl_sid_t stage; logic [NEV-1:0] on; logic [NEV-1:0] off; logic [DW-1:0] stamp;
  } ocsbl_evt_t;
  typedef struct packed {
    logic [DW-1:0] stamp; logic [1:0] code; logic [NPH-1:0] phases; ocsbl_val_t ipre; ocsbl_val_t ifault;
    ocsbl_val_t iavg; ocsbl_time_t tremain; logic [SGW-1:0] sgrp; ocsbl_ang_t angle;
  } ocsbl_rec_t;
  typedef struct packed {
    logic inr_en; logic inverse; ocsbl_val_t iset; ocsbl_val_t tdly; ocsbl_val_t hlim; ocsbl_evsel_t evsel;
    ocsbl_state_t state; logic blk; logic pu; ocsbl_time_t elap; ocsbl_time_t expt; logic [DW-1:0] ratio;
    ocsbl_ang_t angle; ocsbl_ang_t vref; logic [VCW-1:0] vcnt; logic [NEV-1:0] lev;
    logic [CW-1:0] cnt_s; logic [CW-1:0] cnt_t; logic [CW-1:0] cnt_b; ocsbl_evt_t evt; logic rec_wr; ocsbl_rec_t rec;
  } ocsbl_stg_t;
  localparam ocsbl_stg_t STG_RST = '{iset: ISET_RST, tdly: TDLY_RST, hlim: HLIM_RST, evsel: '1,
                                     state: ST_IDLE, default: '0};
endpackage

// ### hw/ocsbl_flog.sv
// Circular store of the most recent fault records of one stage.
// Assumes one write pulse per record; index 0 reads the newest record.
`timescale 1ns/100ps
`default_nettype none
module ocsbl_flog #(
  parameter int DEPTH = ocsbl_pkg::NREC,
  parameter int IW = $clog2(DEPTH)
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_wr,
  input wire ocsbl_pkg::ocsbl_rec_t i_rec,
  input wire logic [IW-1:0] i_idx,
  output ocsbl_pkg::ocsbl_rec_t o_rec,
  output logic [IW-1:0] o_count
);
  import ocsbl_pkg::*;
  ocsbl_rec_t mem [DEPTH];
  ocsbl_rec_t next_mem [DEPTH];
  logic [IW-1:0] wptr, next_wptr;
  logic [IW-1:0] count, next_count;
  int pos;

  always_comb
  begin
    next_mem = mem;
    next_wptr = wptr;
    next_count = count;
    if (i_wr)
    begin
      next_mem[wptr] = i_rec;
      next_wptr = (wptr == IW'(DEPTH - 1)) ? '0 : wptr + IW'(1);
      if (count != IW'(DEPTH))
        next_count = count + IW'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      for (int k = 0; k < DEPTH; k++)
        mem[k] <= '0;
      wptr <= '0;
      count <= '0;
    end
    else
    begin
      mem <= next_mem;
      wptr <= next_wptr;
      count <= next_count;
    end
  end

  // Entries not yet written read as zero, so software sees no stale data after reset.
  always_comb
  begin
    pos = int'(wptr) - 1 - int'(i_idx);
    if (pos < 0)
      pos = pos + DEPTH;
    o_rec = (i_idx < count) ? mem[pos] : '0;
  end
  assign o_count = count;
endmodule
`default_nettype wire

// ### dv/ocsbl_checker.sv
// Concurrent checks on the stage outputs and event pulses of the overcurrent stage event block.
// Assumes it is bound into ocsbl_top and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module ocsbl_checker #(
  parameter int CLKS_PER_MS = ocsbl_pkg::MS_NS / ocsbl_pkg::CLK_NS
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [ocsbl_pkg::NSTG-1:0] o_start,
  input wire logic [ocsbl_pkg::NSTG-1:0] o_trip,
  input wire logic [ocsbl_pkg::NSTG-1:0] o_blocked,
  input wire ocsbl_pkg::ocsbl_evt_t o_evt [ocsbl_pkg::NSTG]
);
  import ocsbl_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  logic [31:0] gap;
  logic [31:0] next_gap;
  logic [DW-1:0] last_stamp;
  logic [DW-1:0] next_last_stamp;
  logic seen;
  logic next_seen;
  // Stage 0 event spacing is tracked so that stamps and tick spacing can be tied together.
  always_comb
  begin
    next_gap = o_evt[0].valid ? 32'h1 : gap + 32'h1;
    next_seen = seen | o_evt[0].valid;
    next_last_stamp = o_evt[0].valid ? o_evt[0].stamp : last_stamp;
  end
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      gap <= 32'h0;
      seen <= 1'b0;
      last_stamp <= '0;
    end
    else
    begin
      gap <= next_gap;
      seen <= next_seen;
      last_stamp <= next_last_stamp;
    end
  end
  sequence s_up(sig);
    !$past(sig) && sig;
  endsequence
  for (genvar s = 0; s < NSTG; s++)
  begin : g_stg
    a_start_blk_excl: assert property (!(o_start[s] && o_blocked[s]))
      else $error("start and blocked high together");
    a_trip_keeps_start: assert property (o_trip[s] |-> o_start[s])
      else $error("trip without start");
    a_trip_after_start: assert property (s_up(o_trip[s]) |-> $past(o_start[s]))
      else $error("trip rose without a prior start");
    a_start_event: assert property ($rose(o_start[s]) |-> o_evt[s].valid && o_evt[s].on[EV_START])
      else $error("start rose without its on event");
    a_on_means_rise: assert property (o_evt[s].valid && o_evt[s].on[EV_START] |-> s_up(o_start[s]))
      else $error("start on event without a rising start");
    a_trip_off_fall: assert property (o_evt[s].valid && o_evt[s].off[EV_TRIP] |-> $fell(o_trip[s]))
      else $error("trip off event without a falling trip");
    a_evt_one_pulse: assert property (o_evt[s].valid |=> !o_evt[s].valid [*8])
      else $error("event valid longer than one cycle");
    a_evt_not_empty: assert property (o_evt[s].valid |-> (|{o_evt[s].on, o_evt[s].off}))
      else $error("event without any change");
  end
  a_stamp_step: assert property (o_evt[0].valid && seen |->
    o_evt[0].stamp > last_stamp && (o_evt[0].stamp - last_stamp) % 32'h5 == 32'h0)
    else $error("event stamp not in tick steps");
  a_tick_spacing: assert property (o_evt[0].valid && seen |-> gap % 32'(5 * CLKS_PER_MS) == 32'h0)
    else $error("events off the processing tick");
endmodule
bind ocsbl_top ocsbl_checker #(.CLKS_PER_MS(CLKS_PER_MS)) u_checker (.i_clk(i_clk), .i_nrst(i_nrst),
  .o_start(o_start), .o_trip(o_trip), .o_blocked(o_blocked), .o_evt(o_evt));
`default_nettype wire

// ### dv/ocsbl_src.sv
// Model of the blocking matrix and measurement source that feed the four stages.
// Assumes the bench states the wanted levels; they reach the pins at the next rising edge.
`timescale 1ns/100ps
`default_nettype none
module ocsbl_src (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [ocsbl_pkg::NSTG-1:0] i_blk_want,
  input wire ocsbl_pkg::ocsbl_meas_t i_meas_want,
  output logic [ocsbl_pkg::NSTG-1:0] o_block,
  output ocsbl_pkg::ocsbl_meas_t o_meas
);
  import ocsbl_pkg::*;
  // Block levels are held for as long as asked, so a caller raising them early is seen in time.
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_block <= '0;
      o_meas <= '0;
    end
    else
    begin
      o_block <= i_blk_want;
      o_meas <= i_meas_want;
    end
  end
endmodule
`default_nettype wire

// ### dv/test_overcurrent_stage_block_event_log.sv
// Self-checking bench for the overcurrent stage event block.
// Assumes a shortened millisecond divider so that one tick lasts 20 clock cycles.
`timescale 1ns/100ps
`default_nettype none
module test_overcurrent_stage_block_event_log;
  import ocsbl_pkg::*;
  localparam int CPM = 4;
  localparam int TICK = 5 * CPM;
  logic i_clk;
  logic i_nrst;
  logic i_wr;
  logic i_rd;
  logic [AW-1:0] i_addr;
  logic [DW-1:0] i_wdata;
  logic [DW-1:0] o_rdata;
  logic [NSTG-1:0] blk_want;
  logic [NSTG-1:0] i_block;
  logic [NSTG-1:0] o_start;
  logic [NSTG-1:0] o_trip;
  logic [NSTG-1:0] o_blocked;
  ocsbl_meas_t meas_want;
  ocsbl_meas_t i_meas;
  ocsbl_evt_t o_evt [NSTG];
  int miscompares;
  int n_compared;
  logic [DW-1:0] rv;
  logic [DW-1:0] r2;
  logic [NEV-1:0] ev;
  ocsbl_src u_src (.i_clk(i_clk), .i_nrst(i_nrst), .i_blk_want(blk_want), .i_meas_want(meas_want),
    .o_block(i_block), .o_meas(i_meas));
  ocsbl_top #(.CLKS_PER_MS(CPM)) dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_block(i_block), .i_meas(i_meas), .o_start(o_start),
    .o_trip(o_trip), .o_blocked(o_blocked), .o_evt(o_evt));
  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [DW-1:0] e, input logic [DW-1:0] g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chkb(input string what, input logic e, input logic g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %b seen %b", what, e, g);
    end
  endtask
  function automatic logic [AW-1:0] ra(input logic [1:0] s, input logic [3:0] i);
    return {1'b0, 3'h0, s, i};
  endfunction
  function automatic logic [AW-1:0] fa(input logic [1:0] s, input logic [3:0] e, input logic [2:0] w);
    return {1'b1, s, e, w};
  endfunction
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic rchk(input string what, input logic [AW-1:0] a, input logic [DW-1:0] e);
    rd(a, rv);
    chk(what, e, rv);
  endtask
  task automatic ticks(input int n);
    repeat (n * TICK) @(posedge i_clk);
    #1;
  endtask
  task automatic drive(input logic [15:0] imax, input logic [NSTG-1:0] blk);
    @(posedge i_clk);
    meas_want.imax <= imax;
    blk_want <= blk;
  endtask
  task automatic t_defaults;
    rchk("ctrl", ra(2'h2, R_CTRL), 32'h0);
    rchk("iset", ra(2'h2, R_ISET), 32'h78);
    rchk("tdly", ra(2'h2, R_TDLY), 32'h14);
    rchk("hlim", ra(2'h2, R_HLIM), 32'h1);
    rchk("evsel", ra(2'h2, R_EVSEL), 32'hfff);
    rchk("unmapped", 10'h0c0, 32'h0);
    wr(ra(2'h2, R_CSTART), 32'h5);
    rchk("ro counter", ra(2'h2, R_CSTART), 32'h0);
    $display("test defaults done");
  endtask
  task automatic t_pickup;
    wr(ra(2'h0, R_ISET), 32'h64);
    wr(ra(2'h0, R_TDLY), 32'h2);
    wr(ra(2'h2, R_HLIM), 32'h32);
    wr(ra(2'h2, R_CTRL), 32'h1);
    meas_want.i2h <= 16'h0064;
    drive(16'h0000, 4'h2);
    ticks(2);
    drive(16'h00c8, 4'h2);
    for (int k = 0; k < 3 * TICK && o_start[0] !== 1'b1; k++)
    begin
      @(posedge i_clk);
      #1;
    end
    chkb("start0", 1'b1, o_start[0]);
    chkb("start1", 1'b0, o_start[1]);
    chkb("blocked1", 1'b1, o_blocked[1]);
    chkb("blocked2", 1'b1, o_blocked[2]);
    chkb("start3", 1'b1, o_start[3]);
    ticks(1);
    chkb("trip0 early", 1'b0, o_trip[0]);
    ticks(1);
    chkb("trip0", 1'b1, o_trip[0]);
    rchk("ratio0", ra(2'h0, R_RATIO), 32'hc8);
    rchk("expt3", ra(2'h3, R_EXPT), 32'h14);
    rd(ra(2'h3, R_REMT), rv);
    repeat (TICK - 2) @(posedge i_clk);
    rd(ra(2'h3, R_REMT), r2);
    chk("remaining", rv - 32'h1, r2);
    rchk("cstart0", ra(2'h0, R_CSTART), 32'h1);
    rchk("ctrip0", ra(2'h0, R_CTRIP), 32'h1);
    rchk("cblk1", ra(2'h1, R_CBLK), 32'h1);
    rchk("rcnt0", ra(2'h0, R_RCNT), 32'h2);
    rd(fa(2'h0, 4'h0, W_INFO), rv);
    chk("code new", 32'h2, {30'h0, rv[8:7]});
    chk("info fields", 32'h9, {25'h0, rv[6:0]});
    rd(fa(2'h0, 4'h1, W_INFO), rv);
    chk("code old", 32'h1, {30'h0, rv[8:7]});
    rchk("fault cur", fa(2'h0, 4'h0, W_IFLT), 32'hc8);
    rchk("pre cur", fa(2'h0, 4'h0, W_IPRE), 32'h11);
    rchk("avg cur", fa(2'h0, 4'h0, W_IAVG), 32'h22);
    rchk("trem start", fa(2'h0, 4'h1, W_TREM), 32'h2);
    rd(fa(2'h0, 4'h1, W_STAMP), r2);
    rd(fa(2'h0, 4'h0, W_STAMP), rv);
    chk("stamp step", r2 + 32'ha, rv);
    $display("test pickup done");
  endtask
  task automatic t_block_late;
    drive(16'h00c8, 4'ha);
    ticks(2);
    chkb("start3 off", 1'b0, o_start[3]);
    chkb("blocked3", 1'b1, o_blocked[3]);
    rchk("remt3", ra(2'h3, R_REMT), 32'h0);
    rd(fa(2'h3, 4'h0, W_INFO), rv);
    chk("code blocked", 32'h3, {30'h0, rv[8:7]});
    $display("test late block done");
  endtask
  task automatic t_hyst;
    drive(16'h0062, 4'h0);
    ticks(2);
    chkb("start0 held", 1'b1, o_start[0]);
    drive(16'h0060, 4'h0);
    ticks(2);
    chkb("start0 released", 1'b0, o_start[0]);
    chkb("trip0 released", 1'b0, o_trip[0]);
    $display("test hysteresis done");
  endtask
  task automatic t_inverse;
    wr(ra(2'h0, R_EVSEL), 32'h03f);
    wr(ra(2'h0, R_TDLY), 32'ha);
    wr(ra(2'h0, R_CTRL), 32'h6);
    rchk("cstart clr", ra(2'h0, R_CSTART), 32'h0);
    rchk("ctrip clr", ra(2'h0, R_CTRIP), 32'h0);
    drive(16'h00c8, 4'h0);
    ticks(2);
    rchk("expt inv", ra(2'h0, R_EXPT), 32'ha);
    drive(16'h012c, 4'h0);
    ticks(2);
    rchk("expt inv hi", ra(2'h0, R_EXPT), 32'h5);
    ev = '0;
    drive(16'h0000, 4'h0);
    for (int k = 0; k < 2 * TICK; k++)
    begin
      @(posedge i_clk);
      #1;
      if (o_evt[0].valid === 1'b1)
        ev = ev | o_evt[0].off;
    end
    chk("off masked", 32'h0, {26'h0, ev});
    chkb("start0 drop", 1'b0, o_start[0]);
    rchk("cstart one", ra(2'h0, R_CSTART), 32'h1);
    $display("test inverse done");
  endtask
  task automatic t_angle;
    @(posedge i_clk);
    meas_want.iang <= 17'h003e8;
    meas_want.uang <= 17'h0012c;
    ticks(2);
    rchk("angle", ra(2'h0, R_ANGLE), 32'h2bc);
    rchk("stat live", ra(2'h0, R_STAT), 32'h10);
    @(posedge i_clk);
    meas_want.vlow <= 1'b1;
    meas_want.uang <= 17'h00384;
    ticks(2);
    rchk("angle held", ra(2'h0, R_ANGLE), 32'h2bc);
    rchk("stat vmem", ra(2'h0, R_STAT), 32'h20);
    ticks(100);
    rchk("angle zero ref", ra(2'h0, R_ANGLE), 32'h3e8);
    rchk("stat novolt", ra(2'h0, R_STAT), 32'h08);
    $display("test angle done");
  endtask
  initial
  begin
    i_nrst = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = '0;
    i_wdata = '0;
    blk_want = '0;
    meas_want = '0;
    meas_want.phases = 4'h1;
    meas_want.sgrp = 3'h1;
    meas_want.ipre = 16'h0011;
    meas_want.iavg = 16'h0022;
    miscompares = 0;
    n_compared = 0;
    repeat (4) @(posedge i_clk);
    i_nrst <= 1'b1;
    t_defaults;
    t_pickup;
    t_block_late;
    t_hyst;
    t_inverse;
    t_angle;
    close_out;
  end
  initial
  begin
    repeat (20000) @(posedge i_clk);
    miscompares++;
    close_out;
  end
endmodule
`default_nettype wire
